/* rtl/fid_timing.sv */
// Summary of operation
// - field flag low in field 1 and progressive, high in field 2 by default.
// - field flag changes exactly at the start of vertical blanking.
// - raster shape comes from the selected standard or the custom registers.
// - genlock locks raster to reference field sync, shifted by offset register 1Bh.
// - polarity register 56h inverts each field and active output.
// - cadence output only for 29.97/30/59.94/60 Hz standards, low otherwise.
// - control bit 4 makes cadence a pulse from sequence start to second field.
// - in genlock the cadence sequence aligns to the cadence reference input.
// - active video flag high only in active region, low during blanking.
// - cadence held high for its marked part, locked to reference cadence.
//
// The implementer's own choices: the placing of the registers and strobed register access.
module fid_timing (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [fid_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fid_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fid_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reference_field_sync_input,
    input wire logic ref_cadence_in,
    output logic field_id_flag,
    output logic ten_field_cadence_id,
    output logic active_video_flag
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] htot;
        logic [15:0] hact;
        logic [15:0] vtot;
        logic [15:0] vact;
        logic [15:0] ofs;
        logic [2:0] pol;
        logic [15:0] rdata;
        logic fs_s1;
        logic fs_s2;
        logic fs_s3;
        logic cr_s1;
        logic cr_s2;
        logic cr_s3;
        logic [3:0] cnt;
        logic fld;
        logic cad;
        logic act;
        logic fld_out;
        logic cad_out;
        logic act_out;
    } fid_top_type;

    fid_top_type s_q;
    fid_top_type s_d;
    fid_pkg::fid_fmt_type fmt;
    logic glk;
    logic cad_mode;
    logic fs_rise;
    logic cr_rise;

    fid_raster_if rif ();

    fid_raster u_raster (
        .core_clk(core_clk),
        .nrst(nrst),
        .rif(rif)
    );

    // format selection: presets or custom registers
    always_comb begin
        case (s_q.ctrl[fid_pkg::CTRL_STD_LSB +: fid_pkg::CTRL_STD_W])
            fid_pkg::STD_1080I: begin
                fmt = fid_pkg::FMT_1080I;
            end
            fid_pkg::STD_720P: begin
                fmt = fid_pkg::FMT_720P;
            end
            fid_pkg::STD_576I: begin
                fmt = fid_pkg::FMT_576I;
            end
            default: begin
                fmt.htot = s_q.htot;
                fmt.hact = s_q.hact;
                fmt.vtot = s_q.vtot;
                fmt.vact = s_q.vact;
                fmt.ilace = s_q.ctrl[fid_pkg::CTRL_ILACE];
                fmt.rate = s_q.ctrl[fid_pkg::CTRL_RATE];
            end
        endcase
    end

    assign glk = s_q.ctrl[fid_pkg::CTRL_GLK];
    assign cad_mode = s_q.ctrl[fid_pkg::CTRL_CADPULSE];
    // edge detectors read only the second and third synchroniser stages
    assign fs_rise = s_q.fs_s2 & ~s_q.fs_s3;
    assign cr_rise = s_q.cr_s2 & ~s_q.cr_s3;

    assign rif.h_total = fmt.htot;
    assign rif.h_active = fmt.hact;
    assign rif.v_total = fmt.vtot;
    assign rif.v_active = fmt.vact;
    assign rif.interlaced = fmt.ilace;
    assign rif.load = glk & fs_rise;
    assign rif.load_line = s_q.ofs;

    always_comb begin
        s_d = s_q;
        s_d.fs_s1 = reference_field_sync_input;
        s_d.fs_s2 = s_q.fs_s1;
        s_d.fs_s3 = s_q.fs_s2;
        s_d.cr_s1 = ref_cadence_in;
        s_d.cr_s2 = s_q.cr_s1;
        s_d.cr_s3 = s_q.cr_s2;

        if (reg_wr) begin
            case (reg_addr)
                fid_pkg::REG_CTRL: begin
                    s_d.ctrl = reg_wdata;
                end
                fid_pkg::REG_HTOT: begin
                    s_d.htot = reg_wdata;
                end
                fid_pkg::REG_HACT: begin
                    s_d.hact = reg_wdata;
                end
                fid_pkg::REG_VTOT: begin
                    s_d.vtot = reg_wdata;
                end
                fid_pkg::REG_VACT: begin
                    s_d.vact = reg_wdata;
                end
                fid_pkg::REG_GLK_OFS: begin
                    s_d.ofs = reg_wdata;
                end
                fid_pkg::REG_POL: begin
                    s_d.pol = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        s_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                fid_pkg::REG_CTRL: begin
                    s_d.rdata = s_q.ctrl;
                end
                fid_pkg::REG_HTOT: begin
                    s_d.rdata = s_q.htot;
                end
                fid_pkg::REG_HACT: begin
                    s_d.rdata = s_q.hact;
                end
                fid_pkg::REG_VTOT: begin
                    s_d.rdata = s_q.vtot;
                end
                fid_pkg::REG_VACT: begin
                    s_d.rdata = s_q.vact;
                end
                fid_pkg::REG_GLK_OFS: begin
                    s_d.rdata = s_q.ofs;
                end
                fid_pkg::REG_POL: begin
                    s_d.rdata = {13'h0000, s_q.pol};
                end
                fid_pkg::REG_STATUS: begin
                    s_d.rdata = {10'h000, s_q.act, s_q.fld, s_q.cnt};
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // reference cadence wins so the next field opens the sequence
        if (glk && cr_rise) begin
            s_d.cnt = fid_pkg::CAD_LAST;
        end else if (rif.field_start) begin
            s_d.cnt = (s_q.cnt >= fid_pkg::CAD_LAST) ? 4'h0 : s_q.cnt + 4'h1;
        end

        s_d.fld = rif.field2;
        s_d.act = rif.active;
        if (!fmt.rate) begin
            s_d.cad = 1'b0;
        end else if (cad_mode) begin
            // pulse opens with the sequence, ends on the second field's first line
            s_d.cad = (s_d.cnt == 4'h0);
        end else begin
            s_d.cad = (s_d.cnt < fid_pkg::CAD_MARK);
        end

        s_d.fld_out = s_d.fld ^ s_d.pol[fid_pkg::POL_FIELD];
        s_d.cad_out = s_d.cad ^ s_d.pol[fid_pkg::POL_CAD];
        s_d.act_out = s_d.act ^ s_d.pol[fid_pkg::POL_ACT];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.ctrl <= fid_pkg::CTRL_RST;
            s_q.htot <= fid_pkg::HTOT_RST;
            s_q.hact <= fid_pkg::HACT_RST;
            s_q.vtot <= fid_pkg::VTOT_RST;
            s_q.vact <= fid_pkg::VACT_RST;
            s_q.ofs <= fid_pkg::OFS_RST;
            s_q.pol <= fid_pkg::POL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign field_id_flag = s_q.fld_out;
    assign ten_field_cadence_id = s_q.cad_out;
    assign active_video_flag = s_q.act_out;

    field_prog_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (!fmt.ilace && !rif.load) [*3] |-> !s_q.fld)
        else $error("field flag high in progressive format");
    field_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
        rif.field_start |=> s_q.fld == $past(rif.field2))
        else $error("field flag missed blanking edge");
    genlock_offset_a: assert property (@(posedge core_clk) disable iff (!nrst)
        glk && fs_rise |-> rif.load && (rif.load_line == s_q.ofs))
        else $error("genlock did not reload raster on reference");
    polarity_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_wr && (reg_addr == fid_pkg::REG_POL) |=> active_video_flag == ($past(rif.active) ^ $past(reg_wdata[2])))
        else $error("active flag polarity not applied");
    cad_rate_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !fmt.rate [*2] |-> !s_q.cad)
        else $error("cadence driven for unsupported rate");
    cad_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(cad_mode && fmt.rate) |-> s_q.cad == (s_q.cnt == 4'h0))
        else $error("cadence pulse outside sequence start");
    cad_align_a: assert property (@(posedge core_clk) disable iff (!nrst)
        glk && cr_rise |=> s_q.cnt == fid_pkg::CAD_LAST)
        else $error("cadence counter not aligned to reference");
    cad_mark_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(!cad_mode && fmt.rate) |-> s_q.cad == (s_q.cnt < fid_pkg::CAD_MARK))
        else $error("cadence mark has wrong extent");
    cad_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        rif.field_start && (s_q.cnt == fid_pkg::CAD_LAST) && !(glk && cr_rise) |=> s_q.cnt == 4'h0)
        else $error("field counter did not wrap after ten fields");
    read_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");

    cad_wrap_c: cover property (@(posedge core_clk) disable iff (!nrst)
        rif.field_start && (s_q.cnt == fid_pkg::CAD_LAST));
    genlock_c: cover property (@(posedge core_clk) disable iff (!nrst) glk && fs_rise);
    field2_c: cover property (@(posedge core_clk) disable iff (!nrst) $rose(s_q.fld));
    cad_pulse_c: cover property (@(posedge core_clk) disable iff (!nrst) cad_mode && $rose(s_q.cad));

endmodule : fid_timing

/* rtl/fid_pkg.sv */
package fid_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HTOT = 8'h01;
    localparam logic [7:0] REG_HACT = 8'h02;
    localparam logic [7:0] REG_VTOT = 8'h03;
    localparam logic [7:0] REG_VACT = 8'h04;
    localparam logic [7:0] REG_GLK_OFS = 8'h1b;
    localparam logic [7:0] REG_POL = 8'h56;
    localparam logic [7:0] REG_STATUS = 8'h60;

    // control register fields
    localparam int CTRL_GLK = 0;
    localparam int CTRL_ILACE = 1;
    localparam int CTRL_RATE = 2;
    localparam int CTRL_CADPULSE = 4;
    localparam int CTRL_STD_LSB = 8;
    localparam int CTRL_STD_W = 3;

    // polarity register fields
    localparam int POL_FIELD = 0;
    localparam int POL_CAD = 1;
    localparam int POL_ACT = 2;

    // values after reset
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] HTOT_RST = 16'h0010;
    localparam logic [15:0] HACT_RST = 16'h000c;
    localparam logic [15:0] VTOT_RST = 16'h000b;
    localparam logic [15:0] VACT_RST = 16'h0004;
    localparam logic [15:0] OFS_RST = 16'h0000;
    localparam logic [2:0] POL_RST = 3'h0;

    // cadence sequence
    localparam logic [3:0] CAD_LAST = 4'h9;
    localparam logic [3:0] CAD_MARK = 4'h5;

    // standard selection codes
    localparam logic [2:0] STD_CUSTOM = 3'h0;
    localparam logic [2:0] STD_1080I = 3'h1;
    localparam logic [2:0] STD_720P = 3'h2;
    localparam logic [2:0] STD_576I = 3'h3;

    typedef struct packed {
        logic [15:0] htot;
        logic [15:0] hact;
        logic [15:0] vtot;
        logic [15:0] vact;
        logic ilace;
        logic rate;
    } fid_fmt_type;

    localparam fid_fmt_type FMT_1080I = '{16'h0898, 16'h0780, 16'h0465, 16'h021c, 1'b1, 1'b1};
    localparam fid_fmt_type FMT_720P = '{16'h0672, 16'h0500, 16'h02ee, 16'h02d0, 1'b0, 1'b1};
    localparam fid_fmt_type FMT_576I = '{16'h0360, 16'h02d0, 16'h0271, 16'h0120, 1'b1, 1'b0};

endpackage : fid_pkg

/* rtl/fid_raster_if.sv */
interface fid_raster_if;
    logic [15:0] h_total;
    logic [15:0] h_active;
    logic [15:0] v_total;
    logic [15:0] v_active;
    logic interlaced;
    logic load;
    logic [15:0] load_line;
    logic field_start;
    logic field2;
    logic active;
    logic first_line;

    modport ctl (
        output h_total, h_active, v_total, v_active, interlaced, load, load_line,
        input field_start, field2, active, first_line
    );
    modport gen (
        input h_total, h_active, v_total, v_active, interlaced, load, load_line,
        output field_start, field2, active, first_line
    );
endinterface : fid_raster_if

/* rtl/fid_raster.sv */
module fid_raster (
    input wire logic core_clk,
    input wire logic nrst,
    fid_raster_if.gen rif
);

    typedef struct packed {
        logic [15:0] px;
        logic [15:0] ln;
        logic fs;
        logic f2;
        logic act;
        logic fl;
    } fid_rst_type;

    fid_rst_type s_q;
    fid_rst_type s_d;

    always_comb begin
        logic [15:0] f1;
        logic [15:0] lf;
        logic [15:0] fl_n;
        f1 = '0;
        lf = '0;
        fl_n = '0;
        s_d = s_q;
        if (rif.load) begin
            s_d.px = '0;
            s_d.ln = (rif.load_line < rif.v_total) ? rif.load_line : 16'h0000;
        end else if (s_q.px >= rif.h_total - 16'h0001) begin
            s_d.px = '0;
            s_d.ln = (s_q.ln >= rif.v_total - 16'h0001) ? 16'h0000 : s_q.ln + 16'h0001;
        end else begin
            s_d.px = s_q.px + 16'h0001;
        end
        f1 = rif.interlaced ? 16'((17'(rif.v_total) + 17'h00001) >> 1) : rif.v_total;
        s_d.f2 = rif.interlaced && (s_d.ln >= f1);
        lf = s_d.f2 ? s_d.ln - f1 : s_d.ln;
        fl_n = s_d.f2 ? rif.v_total - f1 : f1;
        // field start is the leading edge of vertical blanking
        s_d.fs = (s_d.px == 16'h0000) && (lf == 16'h0000);
        s_d.fl = (lf == 16'h0000);
        s_d.act = (s_d.px < rif.h_active) && ((17'(lf) + 17'(rif.v_active)) >= 17'(fl_n));
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rif.field_start = s_q.fs;
    assign rif.field2 = s_q.f2;
    assign rif.active = s_q.act;
    assign rif.first_line = s_q.fl;

    line_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_q.px == rif.h_total - 16'h0001) && !rif.load && $stable(rif.h_total) |=> s_q.px == 16'h0000)
        else $error("pixel count did not wrap at line length");
    field_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(s_q.f2) && !$past(rif.load) && ($past(rif.interlaced) == $past(rif.interlaced, 2))
        && ($past(rif.v_total) == $past(rif.v_total, 2))
        |-> s_q.fs)
        else $error("field flag changed away from blanking start");
    genlock_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
        rif.load && (rif.load_line < rif.v_total) |=> (s_q.ln == $past(rif.load_line)) && (s_q.px == 16'h0000))
        else $error("genlock load did not place raster at offset");
    active_blank_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s_q.act && $stable(rif.h_active) |-> s_q.px < rif.h_active)
        else $error("active video outside active pixels");

endmodule : fid_raster

/* verif/fid_ref_source.sv */
module fid_ref_source #(
    parameter int PULSE_W = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fs_req,
    input wire logic cad_req,
    output logic reference_field_sync_input,
    output logic ref_cadence_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int fs_cnt;
    int cad_cnt;

    // pulses span several clocks so the three-flop synchroniser always sees them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fs_cnt <= 0;
            cad_cnt <= 0;
        end else begin
            fs_cnt <= fs_req ? PULSE_W : (fs_cnt != 0 ? fs_cnt - 1 : 0);
            cad_cnt <= cad_req ? PULSE_W : (cad_cnt != 0 ? cad_cnt - 1 : 0);
        end
    end

    assign reference_field_sync_input = (fs_cnt != 0);
    assign ref_cadence_in = (cad_cnt != 0);
endmodule : fid_ref_source

/* verif/field_id_timing_outputs_tb.sv */
module field_id_timing_outputs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FRAME = int'(fid_pkg::HTOT_RST) * int'(fid_pkg::VTOT_RST);

    logic core_clk;
    logic nrst;
    logic [fid_pkg::ADDR_W-1:0] reg_addr;
    logic [fid_pkg::DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [fid_pkg::DATA_W-1:0] reg_rdata;
    logic ref_fs;
    logic ref_cad;
    logic field_id_flag;
    logic ten_field_cadence_id;
    logic active_video_flag;
    logic fs_req;
    logic cad_req;
    logic [15:0] rdv;
    int n_errors;
    int n_compared;
    int cyc;
    int p;
    int l;
    int c;
    logic [7:0] ra [8] = '{fid_pkg::REG_CTRL, fid_pkg::REG_HTOT, fid_pkg::REG_HACT, fid_pkg::REG_VTOT,
        fid_pkg::REG_VACT, fid_pkg::REG_GLK_OFS, fid_pkg::REG_POL, fid_pkg::REG_STATUS};
    logic [15:0] rv [8] = '{fid_pkg::CTRL_RST, fid_pkg::HTOT_RST, fid_pkg::HACT_RST, fid_pkg::VTOT_RST,
        fid_pkg::VACT_RST, fid_pkg::OFS_RST, {13'h0000, fid_pkg::POL_RST}, 16'h0000};

    fid_timing i_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reference_field_sync_input(ref_fs),
        .ref_cadence_in(ref_cad),
        .field_id_flag(field_id_flag),
        .ten_field_cadence_id(ten_field_cadence_id),
        .active_video_flag(active_video_flag)
    );

    fid_ref_source i_ref (
        .core_clk(core_clk),
        .nrst(nrst),
        .fs_req(fs_req),
        .cad_req(cad_req),
        .reference_field_sync_input(ref_fs),
        .ref_cadence_in(ref_cad)
    );

    always #2.5 core_clk = ~core_clk;

    function automatic logic pick(input int sel);
        return sel == 0 ? field_id_flag : (sel == 1 ? ten_field_cadence_id : active_video_flag);
    endfunction : pick

    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
        @(posedge core_clk);
    endtask : rd

    // counts high cycles of each output over a window; a negative figure is not checked
    task automatic frames(input int n, input int f, input int cd, input int a);
        int cf;
        int cc;
        int ca;
        cf = 0;
        cc = 0;
        ca = 0;
        repeat (n) begin
            @(negedge core_clk);
            cf += (field_id_flag === 1'b1);
            cc += (ten_field_cadence_id === 1'b1);
            ca += (active_video_flag === 1'b1);
        end
        if (f >= 0) chk_rng("field flag high cycles", f, f, cf);
        if (cd >= 0) chk_rng("cadence high cycles", cd, cd, cc);
        if (a >= 0) chk_rng("active high cycles", a, a, ca);
        @(posedge core_clk);
    endtask : frames

    // waits for the output to be low, then measures the wait to its rise and its high run
    task automatic run_len(input int sel, output int pre, output int len);
        pre = 0;
        len = 0;
        do begin @(negedge core_clk); pre++; end while (pick(sel) !== 1'b0 && pre < 4000);
        do begin @(negedge core_clk); pre++; end while (pick(sel) !== 1'b1 && pre < 4000);
        do begin @(negedge core_clk); len++; end while (pick(sel) === 1'b1 && len < 4000);
        @(posedge core_clk);
    endtask : run_len

    // cycles from a reference field sync request to the next active-video rise
    task automatic lock_time(output int n);
        int low;
        n = 0;
        low = 0;
        do begin @(negedge core_clk); n++; end while (active_video_flag !== 1'b1 && n < 400);
        // eight low cycles in a row only happen in vertical blanking, so the load lands before active video
        do begin
            @(negedge core_clk);
            n++;
            low = (active_video_flag === 1'b0) ? low + 1 : 0;
        end while (low < 8 && n < 400);
        @(posedge core_clk);
        fs_req <= 1'b1;
        @(posedge core_clk);
        fs_req <= 1'b0;
        n = 1;
        do begin @(negedge core_clk); n++; end while (active_video_flag !== 1'b1 && n < 400);
        @(posedge core_clk);
    endtask : lock_time

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fs_req = 1'b0;
        cad_req = 1'b0;
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rdv);
            chk("reset value", rv[i], rdv);
        end
        wr(8'h05, 16'h1234);
        rd(8'h05, rdv);
        chk("unmapped read", 16'h0000, rdv);
        wr(fid_pkg::REG_POL, 16'hffff);
        rd(fid_pkg::REG_POL, rdv);
        chk("polarity reg", 16'h0007, rdv);
        frames(FRAME, FRAME, FRAME, FRAME - 48);
        wr(fid_pkg::REG_POL, 16'h0000);
        frames(FRAME, 0, 0, 48);
        wr(fid_pkg::REG_CTRL, 16'h0002);
        repeat (2 * FRAME) @(posedge core_clk);
        frames(FRAME, 80, 0, 96);
        run_len(0, p, l);
        chk_rng("second field length", 80, 80, l);
        wr(fid_pkg::REG_CTRL, 16'h0004);
        run_len(1, p, l);
        run_len(1, p, l);
        chk_rng("cadence mark length", 5 * FRAME, 5 * FRAME, l);
        wr(fid_pkg::REG_CTRL, 16'h0014);
        run_len(1, p, l);
        chk_rng("cadence pulse length", FRAME, FRAME + 16, l);
        wr(fid_pkg::REG_GLK_OFS, 16'h0003);
        wr(fid_pkg::REG_CTRL, 16'h0001);
        lock_time(c);
        chk_rng("lock at offset 3", 67, 73, c);
        wr(fid_pkg::REG_GLK_OFS, 16'h0000);
        lock_time(c);
        chk_rng("lock at offset 0", 115, 121, c);
        wr(fid_pkg::REG_CTRL, 16'h0005);
        cad_req <= 1'b1;
        @(posedge core_clk);
        cad_req <= 1'b0;
        run_len(1, p, l);
        chk_rng("cadence align wait", 1, FRAME + 8, p);
        chk_rng("aligned cadence length", 5 * FRAME, 5 * FRAME, l);
        wr(fid_pkg::REG_CTRL, 16'h0100);
        rd(fid_pkg::REG_STATUS, rdv);
        @(negedge core_clk);
        chk("cadence in 1080i", {15'h0000, rdv[3:0] < 4'h5}, {15'h0000, ten_field_cadence_id});
        wr(fid_pkg::REG_CTRL, 16'h0200);
        rd(fid_pkg::REG_STATUS, rdv);
        @(negedge core_clk);
        chk("cadence in 720p", {15'h0000, rdv[3:0] < 4'h5}, {15'h0000, ten_field_cadence_id});
        @(posedge core_clk);
        wr(fid_pkg::REG_CTRL, 16'h0304);
        frames(2000, -1, 0, -1);
        finish_test();
    end
endmodule : field_id_timing_outputs_tb
